/* File: adccr_params.svh */
// Functional notes
// - left justify: high holds result 9..2
// - left justify: low 7..6 hold result 1..0
// - right justify: high 1..0 hold result 9..8
// - right justify: low holds result 7..0
// - clock codes 011, 111 pick RC clock
// - positive ref: 00 supply, else external pin
// - unimplemented bits ignore writes, read zero
// - config resets zero; results keep contents
// - start flag set by software, hardware clears
// - converter runs only while enabled
//
// Purpose: offsets, fields and config reset value of the converter registers
// Assumes: 32-bit apb data, one aligned word per register
// Notes: definitions only
`ifndef ADCCR_PARAMS_SVH
`define ADCCR_PARAMS_SVH

`define ADCCR_ADDR_W 8
`define ADCCR_OFF_CTRL 8'h00
`define ADCCR_OFF_CFG 8'h04
`define ADCCR_OFF_RES_HI 8'h08
`define ADCCR_OFF_RES_LO 8'h0c

`define ADCCR_CTRL_EN_BIT 0
`define ADCCR_CTRL_GO_BIT 1
`define ADCCR_CFG_JUSTIFY_BIT 7
`define ADCCR_CFG_CLK_MSB 6
`define ADCCR_CFG_CLK_LSB 4
`define ADCCR_CFG_NREF_BIT 2
`define ADCCR_CFG_PREF_MSB 1
`define ADCCR_CFG_PREF_LSB 0

`define ADCCR_HALF_DIV2 6'h01
`define ADCCR_HALF_DIV4 6'h02
`define ADCCR_HALF_DIV8 6'h04
`define ADCCR_HALF_DIV16 6'h08
`define ADCCR_HALF_DIV32 6'h10
`define ADCCR_HALF_DIV64 6'h20

`define ADCCR_CFG_RESET 8'h00
`define ADCCR_CFG_WMASK 8'hf7
`define ADCCR_RES_W 10

`endif

/* File: adccr_pkg.sv */
// Purpose: types of the converter register block
// Assumes: nothing
// Notes: clock select codes as stored in the config register
package adccr_pkg;
	typedef enum logic [2:0] {
		ADCCR_DIV2 = 3'b000,
		ADCCR_DIV8 = 3'b001,
		ADCCR_DIV32 = 3'b010,
		ADCCR_RC_A = 3'b011,
		ADCCR_DIV4 = 3'b100,
		ADCCR_DIV16 = 3'b101,
		ADCCR_DIV64 = 3'b110,
		ADCCR_RC_B = 3'b111
	} adccr_clksel_t;
endpackage

/* File: adccr_regs.sv */
// Purpose: apb register side of a 10-bit converter: control, config, results
// Assumes: core done level and result word come from another clock
// Notes: result word must be stable while done is high
`timescale 1ns/1ns
`include "adccr_params.svh"
module adccr_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADCCR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic conv_done,
	input wire logic [`ADCCR_RES_W-1:0] conv_result,
	output logic converter_enable_bit,
	output logic conv_start,
	output logic conv_clk,
	output logic rc_clock_select,
	output logic neg_ref_select,
	output logic pos_ref_ext
);
	logic [7:0] cfg_reg;
	logic en_reg;
	logic go_reg;
	logic [`ADCCR_RES_W-1:0] result_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic done_s1_reg;
	logic done_s2_reg;
	logic done_s3_reg;
	logic start_reg;
	logic clk_reg;
	logic [5:0] div_cnt_reg;
	logic rc_reg;
	logic nref_reg;
	logic pref_reg;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// half period of the divided clock, in system clocks
	function automatic logic [5:0] div_half(input logic [2:0] code);
		case (code)
			adccr_pkg::ADCCR_DIV2: div_half = `ADCCR_HALF_DIV2;
			adccr_pkg::ADCCR_DIV4: div_half = `ADCCR_HALF_DIV4;
			adccr_pkg::ADCCR_DIV8: div_half = `ADCCR_HALF_DIV8;
			adccr_pkg::ADCCR_DIV16: div_half = `ADCCR_HALF_DIV16;
			adccr_pkg::ADCCR_DIV32: div_half = `ADCCR_HALF_DIV32;
			adccr_pkg::ADCCR_DIV64: div_half = `ADCCR_HALF_DIV64;
			default: div_half = `ADCCR_HALF_DIV2;
		endcase
	endfunction

	wire access = psel && penable && !pready_reg;
	wire commit = psel && penable && pready_reg;
	wire sel_ctrl = paddr == `ADCCR_OFF_CTRL;
	wire sel_cfg = paddr == `ADCCR_OFF_CFG;
	wire sel_hi = paddr == `ADCCR_OFF_RES_HI;
	wire sel_lo = paddr == `ADCCR_OFF_RES_LO;
	wire mapped = sel_ctrl || sel_cfg || sel_hi || sel_lo;
	wire wr = commit && pwrite;
	wire justify = cfg_reg[`ADCCR_CFG_JUSTIFY_BIT];
	wire [2:0] clk_code = cfg_reg[`ADCCR_CFG_CLK_MSB:`ADCCR_CFG_CLK_LSB];
	wire is_rc = clk_code == adccr_pkg::ADCCR_RC_A || clk_code == adccr_pkg::ADCCR_RC_B;
	wire [5:0] half = div_half(clk_code);
	wire done_evt = done_s2_reg && !done_s3_reg && go_reg;
	wire go_set = wr && sel_ctrl && pwdata[`ADCCR_CTRL_GO_BIT] && pwdata[`ADCCR_CTRL_EN_BIT];
	wire res_wr = wr && (sel_hi || sel_lo);

	// justification views of the result word
	wire [7:0] left_hi = result_reg[9:2];
	wire [7:0] left_lo = {result_reg[1:0], 6'h00};
	wire [7:0] right_hi = {6'h00, result_reg[9:8]};
	wire [7:0] right_lo = result_reg[7:0];
	wire [7:0] view_hi = justify ? right_hi : left_hi;
	wire [7:0] view_lo = justify ? right_lo : left_lo;
	wire [7:0] rd_byte = sel_ctrl ? {6'h00, go_reg, en_reg} :
		sel_cfg ? cfg_reg :
		sel_hi ? view_hi :
		sel_lo ? view_lo : 8'h00;

	// software write into the result word, placed by justification
	wire [`ADCCR_RES_W-1:0] res_sw = sel_hi ?
		(justify ? {pwdata[1:0], result_reg[7:0]} : {pwdata[7:0], result_reg[1:0]}) :
		(justify ? {result_reg[9:8], pwdata[7:0]} : {result_reg[9:2], pwdata[7:6]});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= access;
			prdata_reg <= access ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			pslverr_reg <= access && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `ADCCR_CFG_RESET;
			en_reg <= 1'b0;
			go_reg <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			if (wr && sel_cfg) begin
				cfg_reg <= pwdata[7:0] & `ADCCR_CFG_WMASK;
			end
			if (wr && sel_ctrl) begin
				en_reg <= pwdata[`ADCCR_CTRL_EN_BIT];
			end
			// set beats the done clear; disable aborts
			if (go_set) begin
				go_reg <= 1'b1;
			end else if (done_evt || (wr && sel_ctrl && !pwdata[`ADCCR_CTRL_EN_BIT])) begin
				go_reg <= 1'b0;
			end
			start_reg <= go_set && !go_reg;
		end
	end

	// results have no reset: unknown at power-up, kept over later resets
	always_ff @(posedge pclk) begin
		if (done_evt) begin
			result_reg <= conv_result;
		end else if (res_wr) begin
			result_reg <= res_sw;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_s1_reg <= 1'b0;
			done_s2_reg <= 1'b0;
			done_s3_reg <= 1'b0;
		end else begin
			done_s1_reg <= conv_done;
			done_s2_reg <= done_s1_reg;
			done_s3_reg <= done_s2_reg;
		end
	end

	// divided conversion clock; idle low when off or on the rc source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= 6'h00;
			clk_reg <= 1'b0;
		end else if (!en_reg || is_rc) begin
			div_cnt_reg <= 6'h00;
			clk_reg <= 1'b0;
		end else if (div_cnt_reg >= half - 6'h01) begin
			div_cnt_reg <= 6'h00;
			clk_reg <= !clk_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_reg <= 1'b0;
			nref_reg <= 1'b0;
			pref_reg <= 1'b0;
		end else begin
			rc_reg <= is_rc;
			nref_reg <= cfg_reg[`ADCCR_CFG_NREF_BIT];
			pref_reg <= |cfg_reg[`ADCCR_CFG_PREF_MSB:`ADCCR_CFG_PREF_LSB];
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign converter_enable_bit = en_reg;
	assign conv_start = start_reg;
	assign conv_clk = clk_reg;
	assign rc_clock_select = rc_reg;
	assign neg_ref_select = nref_reg;
	assign pos_ref_ext = pref_reg;

	wire rd_acc = access && !pwrite;
	wire [5:0] half_m1 = half - 6'h01;

	// result word known once loaded since the last reset
	logic res_valid_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_valid_reg <= 1'b0;
		end else if (done_evt || res_wr) begin
			res_valid_reg <= 1'b1;
		end
	end

	property p_left_hi;
		rd_acc && sel_hi && !justify |=> prdata_reg[7:0] == $past(left_hi);
	endproperty
	a_left_hi: assert property (p_left_hi) else $error("left high view wrong");

	property p_left_lo;
		rd_acc && sel_lo && !justify |=> prdata_reg[5:0] == 6'h00 &&
			prdata_reg[7:6] == $past(result_reg[1:0]);
	endproperty
	a_left_lo: assert property (p_left_lo) else $error("left low view wrong");

	property p_right_hi;
		rd_acc && sel_hi && justify |=> prdata_reg[7:0] == {6'h00, $past(result_reg[9:8])};
	endproperty
	a_right_hi: assert property (p_right_hi) else $error("right high view wrong");

	property p_right_lo;
		rd_acc && sel_lo && justify |=> prdata_reg[7:0] == $past(result_reg[7:0]);
	endproperty
	a_right_lo: assert property (p_right_lo) else $error("right low view wrong");

	property p_rc_sel;
		$stable(clk_code) |=> rc_clock_select == ($past(clk_code[1:0]) == 2'b11);
	endproperty
	a_rc_sel: assert property (p_rc_sel) else $error("rc select wrong");

	property p_pref;
		##1 pos_ref_ext == ($past(cfg_reg[1:0]) != 2'b00);
	endproperty
	a_pref: assert property (p_pref) else $error("positive ref wrong");

	property p_bit3;
		rd_acc && sel_cfg |=> prdata_reg[3] == 1'b0 && prdata_reg[31:8] == 24'h00_0000;
	endproperty
	a_bit3: assert property (p_bit3) else $error("unimplemented bit not zero");

	property p_res_keep;
		res_valid_reg && !done_evt && !res_wr |=> $stable(result_reg);
	endproperty
	a_res_keep: assert property (p_res_keep) else $error("result changed on its own");

	property p_div;
		en_reg && !is_rc && $stable(half) |-> div_cnt_reg <= half_m1;
	endproperty
	a_div: assert property (p_div) else $error("divider count out of range");

	property p_nref;
		##1 neg_ref_select == $past(cfg_reg[2]);
	endproperty
	a_nref: assert property (p_nref) else $error("negative ref wrong");

	sequence s_busy_done;
		go_reg && !go_set ##0 done_evt;
	endsequence
	property p_done;
		s_busy_done |=> !go_reg && result_reg == $past(conv_result);
	endproperty
	a_done: assert property (p_done) else $error("done did not clear flag");

	sequence s_off;
		!en_reg [*2];
	endsequence
	property p_off;
		s_off |-> !conv_clk && !go_reg && !converter_enable_bit;
	endproperty
	a_off: assert property (p_off) else $error("converter active while off");
endmodule

/* File: adccr_regs_tb.sv */
// Purpose: self-checking bench of the converter register block
// Assumes: one wait state apb slave, core side driven by the bench
// Notes: seed fixed, reserved result bits masked off
`timescale 1ns/1ns
`include "adccr_params.svh"
module adccr_regs_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_done = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, d;
	logic [9:0] conv_result = 10'h000, res;
	logic pready, pslverr, converter_enable_bit, conv_start, conv_clk;
	logic rc_clock_select, neg_ref_select, pos_ref_ext, er;
	int errors = 0, n_checks = 0, seed = 32'hbe07, p, k;
	int per_tbl[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
	adccr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conv_done(conv_done),
		.conv_result(conv_result), .converter_enable_bit(converter_enable_bit),
		.conv_start(conv_start), .conv_clk(conv_clk), .rc_clock_select(rc_clock_select),
		.neg_ref_select(neg_ref_select), .pos_ref_ext(pos_ref_ext));
	initial forever #20 pclk = ~pclk;
	task close_out;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) errors++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// cycles between two rising edges of the conversion clock, 0 if idle
	task per(output int q);
		logic pv;
		q = 0;
		k = 0;
		pv = conv_clk;
		repeat (200) begin
			@(negedge pclk);
			if (conv_clk === 1'b1 && pv === 1'b0) k++;
			if (k == 1) q++;
			pv = conv_clk;
		end
	endtask
	function automatic logic [31:0] f_hi(input logic j, input logic [9:0] r);
		return j ? {30'h0, r[9:8]} : {24'h0, r[9:2]};
	endfunction
	function automatic logic [31:0] f_lo(input logic j, input logic [9:0] r);
		return j ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h00};
	endfunction
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		close_out;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(`ADCCR_OFF_CFG, 1'b0, 32'h0);
		chk("cfg reset", rd, 32'h0);
		apb(`ADCCR_OFF_CTRL, 1'b1, 32'h1);
		for (int c = 0; c < 8; c++) begin
			d = $random(seed);
			d[6:4] = c[2:0];
			d[3] = 1'b1;
			d[1:0] = (c[1:0] == 2'b01) ? 2'b11 : c[1:0];
			apb(`ADCCR_OFF_CFG, 1'b1, d);
			repeat (2) @(posedge pclk);
			apb(`ADCCR_OFF_CFG, 1'b0, 32'h0);
			chk("cfg", rd, d & 32'hf7);
			chk("rc sel", rc_clock_select, c[1:0] == 2'b11);
			chk("nref", neg_ref_select, d[2]);
			chk("pref", pos_ref_ext, d[1:0] != 2'b00);
			per(p);
			chk("period", p, per_tbl[c]);
			$display("clock code %0d done", c);
		end
		for (int i = 0; i < 8; i++) begin
			res = (i < 2) ? 10'h3ff : 10'($random(seed));
			apb(`ADCCR_OFF_CFG, 1'b1, {24'h0, i[0], 7'h00});
			apb(`ADCCR_OFF_CTRL, 1'b1, 32'h3);
			k = 0;
			repeat (4) begin
				@(negedge pclk);
				if (conv_start === 1'b1) k++;
			end
			chk("start", k, 1);
			apb(`ADCCR_OFF_CTRL, 1'b0, 32'h0);
			chk("busy", rd, 32'h3);
			conv_result <= res;
			conv_done <= 1'b1;
			repeat (6) @(posedge pclk);
			conv_done <= 1'b0;
			conv_result <= ~res;
			apb(`ADCCR_OFF_CTRL, 1'b0, 32'h0);
			chk("go clear", rd, 32'h1);
			apb(`ADCCR_OFF_RES_HI, 1'b0, 32'h0);
			chk("hi", rd & (i[0] ? 32'h3 : 32'hff), f_hi(i[0], res));
			apb(`ADCCR_OFF_RES_LO, 1'b0, 32'h0);
			chk("lo", rd & (i[0] ? 32'hff : 32'hc0), f_lo(i[0], res));
			$display("conversion %0d done", i);
		end
		apb(`ADCCR_OFF_RES_LO, 1'b1, 32'ha5);
		res[7:0] = 8'ha5;
		conv_done <= 1'b1;
		repeat (6) @(posedge pclk);
		conv_done <= 1'b0;
		apb(`ADCCR_OFF_RES_LO, 1'b0, 32'h0);
		chk("sw lo", rd, f_lo(1'b1, res));
		apb(`ADCCR_OFF_RES_HI, 1'b0, 32'h0);
		chk("idle done", rd & 32'h3, f_hi(1'b1, res));
		$display("result write test done");
		apb(`ADCCR_OFF_CTRL, 1'b1, 32'h2);
		apb(`ADCCR_OFF_CTRL, 1'b0, 32'h0);
		chk("go off", rd, 32'h0);
		chk("enable", converter_enable_bit, 1'b0);
		per(p);
		chk("clk off", p, 0);
		apb(8'h40, 1'b0, 32'h0);
		chk("unmapped", {er, rd[30:0]}, 32'h80000000);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(`ADCCR_OFF_CFG, 1'b0, 32'h0);
		chk("cfg rst2", rd, 32'h0);
		apb(`ADCCR_OFF_RES_LO, 1'b0, 32'h0);
		chk("res kept", rd & 32'hc0, f_lo(1'b0, res));
		$display("reset and refusal tests done");
		close_out;
	end
endmodule
